// ===== logic/rcu_pkg.sv
package rcu_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h08;
   localparam logic [7:0] STS_OFS = 8'h0c;
   localparam logic [7:0] IRQ_STS_OFS = 8'h10;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
   localparam logic [7:0] IRQ_EN_OFS = 8'h18;
   // control field positions
   localparam int STAMP_CAPTURE_ON_BIT = 11;
   localparam int ALARM_IRQ_ON_BIT = 12;
   localparam int WAKE_IRQ_ON_BIT = 14;
   localparam int STAMP_IRQ_ON_BIT = 15;
   localparam int ADD_HOUR_CMD_BIT = 16;
   localparam int SUB_HOUR_CMD_BIT = 17;
   localparam int DST_MEMO_BIT = 18;
   localparam int CAL_FREQ_PICK_BIT = 19;
   localparam int OUT_LEVEL_PICK_BIT = 20;
   localparam int OUT_ROUTE_LO = 21;
   localparam int CAL_OUT_ON_BIT = 23;
   // control bits that store a value (11,12,14,15,18..23)
   localparam logic [31:0] CTRL_STORE_MASK = 32'h00fcd800;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   // status field positions
   localparam int INIT_ACTIVE_BIT = 6;
   localparam int INIT_MODE_REQUEST_BIT = 7;
   localparam int ALARM_MATCH_FLAG_BIT = 8;
   localparam int WAKE_COUNT_FLAG_BIT = 10;
   localparam int STAMP_FLAG_BIT = 11;
   localparam int STAMP_OVR_FLAG_BIT = 12;
   localparam logic [31:0] STS_RESET = 32'h00000007;
   // writable-under-protection status field (13:8)
   localparam logic [31:0] STS_OPEN_MASK = 32'h00003f00;
   // output route codes
   localparam logic [1:0] ROUTE_OFF = 2'h0;
   localparam logic [1:0] ROUTE_ALARM = 2'h1;
   localparam logic [1:0] ROUTE_WAKE = 2'h3;
   // interrupt event positions
   localparam int EV_ALARM = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_STAMP = 2;
   localparam int EV_W = 3;
endpackage

// ===== logic/rcu_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rcu_ctrl
   import rcu_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_write_protect,
   input wire logic i_alarm_match,
   input wire logic i_wake_zero,
   input wire logic i_stamp_pin,
   input wire logic i_stamp_falling,
   input wire logic i_second_tick,
   input wire logic i_hour_digits_zero,
   input wire logic i_tap_512hz,
   input wire logic i_tap_1hz,
   output logic o_calendar_run,
   output logic o_add_hour,
   output logic o_sub_hour,
   output logic o_stamp_capture,
   output logic o_alarm_pin,
   output logic o_alarm_pin_oe,
   output logic o_cal_clock_pin,
   output logic o_cal_clock_pin_oe,
   output logic o_irq
);

   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [31:0] sts;
   logic [31:0] next_sts;
   logic [EV_W-1:0] irq_sts;
   logic [EV_W-1:0] next_irq_sts;
   logic [EV_W-1:0] irq_en;
   logic [EV_W-1:0] next_irq_en;
   logic add_pend;
   logic next_add_pend;
   logic sub_pend;
   logic next_sub_pend;
   logic add_pulse;
   logic next_add_pulse;
   logic sub_pulse;
   logic next_sub_pulse;
   logic [2:0] stamp_sync;
   logic [2:0] next_stamp_sync;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic alarm_pin;
   logic next_alarm_pin;
   logic alarm_oe;
   logic next_alarm_oe;
   logic cal_pin;
   logic next_cal_pin;
   logic cal_oe;
   logic next_cal_oe;
   logic stamp_edge;
   logic in_init;
   logic wr_ctrl;
   logic wr_sts;
   logic [EV_W-1:0] events;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign in_init = sts[INIT_MODE_REQUEST_BIT];
   assign wr_ctrl = i_wr && hit(i_addr, CTRL_OFS) && !i_write_protect;
   assign wr_sts = i_wr && hit(i_addr, STS_OFS);

   // stamp pin edge on synchronised samples, gated by capture enable
   always_comb begin
      next_stamp_sync = {stamp_sync[1:0], i_stamp_pin};
      if (i_stamp_falling) begin
         stamp_edge = stamp_sync[2] && !stamp_sync[1];
      end else begin
         stamp_edge = !stamp_sync[2] && stamp_sync[1];
      end
      stamp_edge = stamp_edge && ctrl[STAMP_CAPTURE_ON_BIT];
   end

   // control register: command bits never stored, memo bit only stored
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = i_wdata & CTRL_STORE_MASK;
      end
   end

   // hour commands wait for the next second tick
   always_comb begin
      next_add_pend = add_pend;
      next_sub_pend = sub_pend;
      next_add_pulse = 1'b0;
      next_sub_pulse = 1'b0;
      if (i_second_tick && !in_init) begin
         next_add_pulse = add_pend;
         next_sub_pulse = sub_pend && !i_hour_digits_zero;
         next_add_pend = 1'b0;
         next_sub_pend = 1'b0;
      end
      if (in_init) begin
         next_add_pend = 1'b0;
         next_sub_pend = 1'b0;
      end
      if (wr_ctrl && !in_init) begin
         if (i_wdata[ADD_HOUR_CMD_BIT]) begin
            next_add_pend = 1'b1;
         end
         if (i_wdata[SUB_HOUR_CMD_BIT]) begin
            next_sub_pend = 1'b1;
         end
      end
   end

   // status register: writes to 0 clear flags, hardware set wins
   always_comb begin
      next_sts = sts;
      if (wr_sts) begin
         if (!i_write_protect) begin
            next_sts[INIT_MODE_REQUEST_BIT] = i_wdata[INIT_MODE_REQUEST_BIT];
         end
         next_sts = next_sts & (~STS_OPEN_MASK | i_wdata);
      end
      next_sts[INIT_ACTIVE_BIT] = sts[INIT_MODE_REQUEST_BIT];
      if (i_alarm_match) begin
         next_sts[ALARM_MATCH_FLAG_BIT] = 1'b1;
      end
      if (i_wake_zero) begin
         next_sts[WAKE_COUNT_FLAG_BIT] = 1'b1;
      end
      if (stamp_edge) begin
         next_sts[STAMP_FLAG_BIT] = 1'b1;
         if (sts[STAMP_FLAG_BIT]) begin
            next_sts[STAMP_OVR_FLAG_BIT] = 1'b1;
         end
      end
   end

   // sticky interrupt status, write-one clear, set wins over clear
   always_comb begin
      events = '0;
      events[EV_ALARM] = i_alarm_match && ctrl[ALARM_IRQ_ON_BIT];
      events[EV_WAKE] = i_wake_zero && ctrl[WAKE_IRQ_ON_BIT];
      events[EV_STAMP] = stamp_edge && ctrl[STAMP_IRQ_ON_BIT];
      next_irq_sts = irq_sts;
      next_irq_en = irq_en;
      if (i_wr && hit(i_addr, IRQ_CLR_OFS)) begin
         next_irq_sts = irq_sts & ~i_wdata[EV_W-1:0];
      end
      if (i_wr && hit(i_addr, IRQ_EN_OFS)) begin
         next_irq_en = i_wdata[EV_W-1:0];
      end
      next_irq_sts = next_irq_sts | events;
   end

   // output pins: alarm routing and polarity, calibration tap select
   always_comb begin
      next_alarm_oe = 1'b1;
      next_alarm_pin = 1'b0;
      unique case (ctrl[OUT_ROUTE_LO +: 2])
         ROUTE_ALARM: next_alarm_pin = sts[ALARM_MATCH_FLAG_BIT];
         ROUTE_WAKE: next_alarm_pin = sts[WAKE_COUNT_FLAG_BIT];
         default: next_alarm_oe = 1'b0;
      endcase
      // flag set drives the inverse of the level pick bit, clear drives the bit's own value
      next_alarm_pin = next_alarm_pin ^ ctrl[OUT_LEVEL_PICK_BIT] ^ 1'b0;
      if (ctrl[OUT_LEVEL_PICK_BIT]) begin
         next_alarm_pin = !(next_alarm_pin ^ 1'b1);
      end
      next_alarm_pin = next_alarm_oe && next_alarm_pin;
      next_cal_oe = ctrl[CAL_OUT_ON_BIT];
      next_cal_pin = 1'b0;
      if (ctrl[CAL_OUT_ON_BIT]) begin
         next_cal_pin = ctrl[CAL_FREQ_PICK_BIT] ? i_tap_1hz : i_tap_512hz;
      end
   end

   // read data, valid in the cycle after the read strobe
   always_comb begin
      next_rdata = '0;
      if (i_rd) begin
         if (hit(i_addr, CTRL_OFS)) begin
            next_rdata = ctrl;
         end else if (hit(i_addr, STS_OFS)) begin
            next_rdata = sts;
         end else if (hit(i_addr, IRQ_STS_OFS)) begin
            next_rdata[EV_W-1:0] = irq_sts;
         end else if (hit(i_addr, IRQ_EN_OFS)) begin
            next_rdata[EV_W-1:0] = irq_en;
         end
      end
   end

   // stamp pin synchroniser and edge history
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         stamp_sync <= '0;
      end else begin
         stamp_sync <= next_stamp_sync;
      end
   end

   // control register
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ctrl <= CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // pending hour commands and their pulses
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         add_pend <= 1'b0;
         sub_pend <= 1'b0;
         add_pulse <= 1'b0;
         sub_pulse <= 1'b0;
      end else begin
         add_pend <= next_add_pend;
         sub_pend <= next_sub_pend;
         add_pulse <= next_add_pulse;
         sub_pulse <= next_sub_pulse;
      end
   end

   // status register
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         sts <= STS_RESET;
      end else begin
         sts <= next_sts;
      end
   end

   // interrupt status and enable
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         irq_sts <= '0;
         irq_en <= '0;
      end else begin
         irq_sts <= next_irq_sts;
         irq_en <= next_irq_en;
      end
   end

   // output pin flops
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         alarm_pin <= 1'b0;
         alarm_oe <= 1'b0;
         cal_pin <= 1'b0;
         cal_oe <= 1'b0;
      end else begin
         alarm_pin <= next_alarm_pin;
         alarm_oe <= next_alarm_oe;
         cal_pin <= next_cal_pin;
         cal_oe <= next_cal_oe;
      end
   end

   // read data flop
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   // outputs
   assign o_rdata = rdata;
   assign o_calendar_run = !in_init;
   assign o_add_hour = add_pulse;
   assign o_sub_hour = sub_pulse;
   assign o_stamp_capture = stamp_edge;
   assign o_alarm_pin = alarm_pin;
   assign o_alarm_pin_oe = alarm_oe;
   assign o_cal_clock_pin = cal_pin;
   assign o_cal_clock_pin_oe = cal_oe;
   assign o_irq = |(irq_sts & irq_en);

endmodule
`default_nettype wire

// ===== verification/rcu_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level timing checks of the clock control block
module rcu_ctrl_chk (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [31:0] o_rdata,
   input wire logic i_alarm_match,
   input wire logic i_wake_zero,
   input wire logic i_second_tick,
   input wire logic i_hour_digits_zero,
   input wire logic i_tap_512hz,
   input wire logic i_tap_1hz,
   input wire logic o_calendar_run,
   input wire logic o_add_hour,
   input wire logic o_sub_hour,
   input wire logic o_stamp_capture,
   input wire logic o_alarm_pin,
   input wire logic o_alarm_pin_oe,
   input wire logic o_cal_clock_pin,
   input wire logic o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // a pulse lasts exactly one cycle
   sequence s_one;
      o_add_hour ##1 !o_add_hour;
   endsequence
   property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
   property p_pulse; o_add_hour |-> s_one; endproperty
   property p_add; o_add_hour |-> $past(i_second_tick); endproperty
   property p_sub; o_sub_hour |-> $past(i_second_tick) && !$past(i_hour_digits_zero); endproperty
   property p_run; (o_add_hour || o_sub_hour) |-> $past(o_calendar_run); endproperty
   property p_pin_off; !o_alarm_pin_oe |-> !o_alarm_pin; endproperty
   property p_cal; o_cal_clock_pin |-> $past(i_tap_512hz) || $past(i_tap_1hz); endproperty
   property p_irq;
      $rose(o_irq) |-> $past(i_wr) || $past(i_alarm_match) || $past(i_wake_zero) ||
         $past(o_stamp_capture) || $past(o_stamp_capture, 2);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_pulse: assert property (p_pulse) else $error("add pulse too long");
   a_add: assert property (p_add) else $error("add hour off second");
   a_sub: assert property (p_sub) else $error("bad sub hour");
   a_run: assert property (p_run) else $error("hour change in init");
   a_pin_off: assert property (p_pin_off) else $error("alarm pin driven while off");
   a_cal: assert property (p_cal) else $error("cal pin without tap");
   a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
bind rcu_ctrl rcu_ctrl_chk rcu_ctrl_chk_i (
   .i_ref_clk(i_ref_clk),
   .i_reset(i_reset),
   .i_rd(i_rd),
   .i_wr(i_wr),
   .o_rdata(o_rdata),
   .i_alarm_match(i_alarm_match),
   .i_wake_zero(i_wake_zero),
   .i_second_tick(i_second_tick),
   .i_hour_digits_zero(i_hour_digits_zero),
   .i_tap_512hz(i_tap_512hz),
   .i_tap_1hz(i_tap_1hz),
   .o_calendar_run(o_calendar_run),
   .o_add_hour(o_add_hour),
   .o_sub_hour(o_sub_hour),
   .o_stamp_capture(o_stamp_capture),
   .o_alarm_pin(o_alarm_pin),
   .o_alarm_pin_oe(o_alarm_pin_oe),
   .o_cal_clock_pin(o_cal_clock_pin),
   .o_irq(o_irq)
);
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rcu_pkg::*;
   logic i_ref_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_write_protect = 0, i_alarm_match = 0;
   logic i_wake_zero = 0, i_stamp_pin = 0, i_stamp_falling = 0, i_second_tick = 0;
   logic i_hour_digits_zero = 0, i_tap_512hz = 0, i_tap_1hz = 0;
   logic [7:0] i_addr = 8'h0;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic o_calendar_run, o_add_hour, o_sub_hour, o_stamp_capture, o_alarm_pin, o_alarm_pin_oe;
   logic o_cal_clock_pin, o_cal_clock_pin_oe, o_irq;
   int errors = 0, cmp_count = 0, cyc = 0, ncap = 0;
   rcu_ctrl rcu_ctrl_i (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .i_write_protect(i_write_protect),
      .i_alarm_match(i_alarm_match),
      .i_wake_zero(i_wake_zero),
      .i_stamp_pin(i_stamp_pin),
      .i_stamp_falling(i_stamp_falling),
      .i_second_tick(i_second_tick),
      .i_hour_digits_zero(i_hour_digits_zero),
      .i_tap_512hz(i_tap_512hz),
      .i_tap_1hz(i_tap_1hz),
      .o_calendar_run(o_calendar_run),
      .o_add_hour(o_add_hour),
      .o_sub_hour(o_sub_hour),
      .o_stamp_capture(o_stamp_capture),
      .o_alarm_pin(o_alarm_pin),
      .o_alarm_pin_oe(o_alarm_pin_oe),
      .o_cal_clock_pin(o_cal_clock_pin),
      .o_cal_clock_pin_oe(o_cal_clock_pin_oe),
      .o_irq(o_irq)
   );
   // clock and cycle limit
   always #25 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         $display("mismatch at %0t: cycle limit reached", $time);
         give_verdict();
      end
   end
   // stamp pulses counted mid-cycle, clear of the edge that launches them
   always @(negedge i_ref_clk) begin
      if (o_stamp_capture === 1'b1) ncap++;
   end
   task automatic give_verdict();
      $display("errors %0d of %0d compares", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_ref_clk);
      i_rd <= 1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 0;
      #1;
      ck(o_rdata, e);
   endtask
   task automatic tick();
      @(posedge i_ref_clk);
      i_second_tick <= 1;
      @(posedge i_ref_clk);
      i_second_tick <= 0;
      #1;
   endtask
   task automatic ev(input logic al, input logic wk);
      @(posedge i_ref_clk);
      i_alarm_match <= al;
      i_wake_zero <= wk;
      @(posedge i_ref_clk);
      i_alarm_match <= 0;
      i_wake_zero <= 0;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_reset <= 0;
      rd(STS_OFS, STS_RESET);
      rd(8'h04, 32'h0);
      wr(CTRL_OFS, 32'h00ffd800);
      rd(CTRL_OFS, 32'h00fcd800);
      ck(o_add_hour, 0);
      tick();
      ck({o_add_hour, o_sub_hour}, 3);
      w(1);
      ck(o_add_hour, 0);
      wr(CTRL_OFS, 32'h00020000);
      i_hour_digits_zero <= 1;
      tick();
      ck(o_sub_hour, 0);
      i_hour_digits_zero <= 0;
      wr(STS_OFS, 32'h80);
      ck(o_calendar_run, 0);
      wr(CTRL_OFS, 32'h00010000);
      wr(STS_OFS, 32'h0);
      tick();
      ck(o_add_hour, 0);
      wr(CTRL_OFS, 32'h00200000);
      w(1);
      ck({o_alarm_pin_oe, o_alarm_pin}, 2);
      ev(1, 0);
      w(2);
      ck(o_alarm_pin, 1);
      rd(IRQ_STS_OFS, 32'h0);
      wr(CTRL_OFS, 32'h00300000);
      w(1);
      ck(o_alarm_pin, 0);
      wr(CTRL_OFS, 32'h00700000);
      w(1);
      ck({o_alarm_pin_oe, o_alarm_pin}, 3);
      wr(CTRL_OFS, 32'h0);
      w(1);
      ck(o_alarm_pin_oe, 0);
      i_write_protect <= 1;
      wr(STS_OFS, 32'h80);
      rd(STS_OFS, STS_RESET);
      wr(CTRL_OFS, 32'h00040000);
      rd(CTRL_OFS, 32'h0);
      i_write_protect <= 0;
      wr(CTRL_OFS, 32'h00045000);
      wr(IRQ_EN_OFS, 32'h3);
      ev(1, 1);
      w(2);
      ck(o_irq, 1);
      rd(IRQ_STS_OFS, 32'h3);
      wr(IRQ_EN_OFS, 32'h0);
      ck(o_irq, 0);
      wr(IRQ_CLR_OFS, 32'h3);
      rd(IRQ_STS_OFS, 32'h0);
      wr(CTRL_OFS, 32'h0);
      i_stamp_pin <= 1;
      w(6);
      ck(ncap, 0);
      i_stamp_pin <= 0;
      wr(CTRL_OFS, 32'h00000800);
      i_stamp_pin <= 1;
      w(6);
      ck(ncap, 1);
      wr(IRQ_EN_OFS, 32'h4);
      wr(CTRL_OFS, 32'h00008800);
      i_stamp_falling <= 1;
      i_stamp_pin <= 0;
      w(6);
      ck(ncap, 2);
      rd(IRQ_STS_OFS, 32'h4);
      i_tap_512hz <= 1;
      wr(CTRL_OFS, 32'h00800000);
      w(2);
      ck({o_cal_clock_pin_oe, o_cal_clock_pin}, 3);
      wr(CTRL_OFS, 32'h00880000);
      w(2);
      ck(o_cal_clock_pin, 0);
      give_verdict();
   end
endmodule
`default_nettype wire
